// file: design/pad_mux_pkg.sv
// Constants, field layouts and encodings for the port A low pad multiplexer
package pad_mux_pkg;
  localparam int PAD_COUNT = 4;
  localparam int CFG_WIDTH = 16;
  localparam int FIELD_WIDTH = 4;
  localparam int REMAP_WIDTH = 8;
  localparam int PIN_SEL_WIDTH = 5;
  localparam int SYNC_STAGES = 2;
  // Remap option bit positions per timer 2 channel
  localparam int REMAP_CH1_BIT = 4;
  localparam int REMAP_CH2_BIT = 5;
  localparam int REMAP_CH3_BIT = 6;
  localparam int REMAP_CH4_BIT = 7;
  // Role bit in the SPI configuration: set means master
  localparam int SPI_MASTER_BIT = 4;
  localparam int SPI_CFG_WIDTH = 8;
  // Pad configuration field encodings
  localparam logic [3:0] CFG_ANALOG = 4'h0;
  localparam logic [3:0] CFG_OUT = 4'h1;
  localparam logic [3:0] CFG_IN = 4'h4;
  localparam logic [3:0] CFG_ALT_OUT = 4'h9;
  localparam logic [3:0] CFG_ALT_OD = 4'hd;
  localparam logic [CFG_WIDTH-1:0] CFG_RESET = 16'h4444;
  // Serial controller mode encodings
  typedef enum logic [1:0] {
    SER_MODE_OFF = 2'h0,
    SER_MODE_UART = 2'h1,
    SER_MODE_SPI = 2'h2,
    SER_MODE_TWI = 2'h3
  } serial_mode_t;
  // Output source chosen for one pad
  typedef enum logic [2:0] {
    SRC_GPIO,
    SRC_TIMER,
    SRC_SPI_OUT,
    SRC_TWI_OD,
    SRC_ANALOG
  } pad_source_t;
endpackage : pad_mux_pkg

// file: design/pad_sync_if.sv
// Carrier between the pad driver and its input synchroniser
`timescale 1ns/1ps
`default_nettype none
interface pad_sync_if #(parameter int WIDTH = 4);
  logic [WIDTH-1:0] raw;
  logic [WIDTH-1:0] synced;
  modport producer (output raw, input synced);
  modport sync (input raw, output synced);
endinterface : pad_sync_if
`default_nettype wire

// file: design/pad_input_sync.sv
// Two flip-flop synchroniser for pad input levels
`timescale 1ns/1ps
`default_nettype none
module pad_input_sync
(
  input wire logic clk,
  input wire logic rst_n,
  pad_sync_if.sync port
);
  import pad_mux_pkg::*;
  logic [$bits(port.raw)-1:0] meta_reg;
  logic [$bits(port.raw)-1:0] sync_reg;

  // First stage is read only by the second
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_reg <= '0;
      sync_reg <= '0;
    end
    else
    begin
      meta_reg <= port.raw;
      sync_reg <= meta_reg;
    end
  end

  assign port.synced = sync_reg;
endmodule : pad_input_sync
`default_nettype wire

// file: design/port_a_low_pin_mux.sv
// Port A low pad multiplexer: GPIO, USB, timer 2, serial controller 2, flex interrupts
`timescale 1ns/1ps
`default_nettype none
module port_a_low_pin_mux
#(
  parameter int DIGITAL_PADS = 32,
  parameter bit USB_FITTED = 1'b1
)
(
  input wire logic REF_CLK,
  input wire logic RESETN,
  input wire logic [pad_mux_pkg::CFG_WIDTH-1:0] PORT_A_LOW_PAD_CONFIG,
  input wire logic [pad_mux_pkg::PAD_COUNT-1:0] GPIO_OUT,
  input wire logic [pad_mux_pkg::REMAP_WIDTH-1:0] TIMER2_REMAP_OPTIONS,
  input wire logic [pad_mux_pkg::PAD_COUNT-1:0] TIMER2_CHANNEL_OUTPUT_ENABLES,
  input wire logic [pad_mux_pkg::PAD_COUNT-1:0] TIMER2_CHANNEL_OUT,
  input wire logic [pad_mux_pkg::SPI_CFG_WIDTH-1:0] SERIAL2_SPI_CONFIG,
  input wire pad_mux_pkg::serial_mode_t SERIAL2_MODE_SELECT,
  input wire logic SERIAL2_SPI_MASTER_OUT,
  input wire logic SERIAL2_SPI_SLAVE_OUT,
  input wire logic SERIAL2_SPI_CLOCK_OUT,
  input wire logic SERIAL2_TWI_DATA_OUT,
  input wire logic SERIAL2_TWI_CLOCK_OUT,
  input wire logic [pad_mux_pkg::PAD_COUNT-1:0] PORT_A_PAD_IN,
  input wire logic [3:0] PORT_B_REMAP_PAD_IN,
  input wire logic [DIGITAL_PADS-1:0] DIGITAL_PAD_IN,
  input wire logic [pad_mux_pkg::PIN_SEL_WIDTH-1:0] FLEX_INTERRUPT_THREE_PIN_SELECT,
  input wire logic [pad_mux_pkg::PIN_SEL_WIDTH-1:0] FLEX_INTERRUPT_FOUR_PIN_SELECT,
  output logic [pad_mux_pkg::PAD_COUNT-1:0] PORT_A_PAD_OUT,
  output logic [pad_mux_pkg::PAD_COUNT-1:0] PORT_A_PAD_OE,
  output logic USB_MINUS_LINE_EN,
  output logic USB_PLUS_LINE_EN,
  output logic [3:0] PORT_B_REMAP_OUT,
  output logic [3:0] PORT_B_REMAP_OE,
  output logic [pad_mux_pkg::PAD_COUNT-1:0] TIMER2_CHANNEL_IN,
  output logic SERIAL2_SPI_MASTER_IN,
  output logic SERIAL2_SPI_SLAVE_IN,
  output logic SERIAL2_SPI_CLOCK_IN,
  output logic SERIAL2_SPI_SLAVE_SELECT_N,
  output logic SERIAL2_TWI_DATA_IN,
  output logic SERIAL2_TWI_CLOCK_IN,
  output logic [pad_mux_pkg::PAD_COUNT-1:0] GPIO_IN,
  output logic FLEX_INTERRUPT_THREE,
  output logic FLEX_INTERRUPT_FOUR
);
  import pad_mux_pkg::*;

  localparam int SYNC_W = PAD_COUNT + 4 + DIGITAL_PADS;

  logic [FIELD_WIDTH-1:0] field [PAD_COUNT];
  logic [PAD_COUNT-1:0] remapped;
  logic [PAD_COUNT-1:0] timer_drive;
  logic [PAD_COUNT-1:0] timer_free;
  logic spi_mode;
  logic twi_mode;
  logic spi_master;
  pad_source_t source [PAD_COUNT];
  logic [PAD_COUNT-1:0] pad_out_next;
  logic [PAD_COUNT-1:0] pad_oe_next;
  logic [3:0] port_b_out_next;
  logic [3:0] port_b_oe_next;
  logic [PAD_COUNT-1:0] pad_in;
  logic [3:0] port_b_in;
  logic [DIGITAL_PADS-1:0] digital_in;
  logic [PAD_COUNT-1:0] timer_in_next;

  // All pad levels are asynchronous to the core and are synchronised together
  pad_sync_if #(.WIDTH(SYNC_W)) pad_sync ();
  assign pad_sync.raw = {DIGITAL_PAD_IN, PORT_B_REMAP_PAD_IN, PORT_A_PAD_IN};
  assign pad_in = pad_sync.synced[PAD_COUNT-1:0];
  assign port_b_in = pad_sync.synced[PAD_COUNT+3:PAD_COUNT];
  assign digital_in = pad_sync.synced[SYNC_W-1:PAD_COUNT+4];

  pad_input_sync u_sync
  (
    .clk(REF_CLK),
    .rst_n(RESETN),
    .port(pad_sync.sync)
  );

  // Timer channel n is index n-1; pad 0..3 carry channels 1,3,4,2
  assign remapped[0] = TIMER2_REMAP_OPTIONS[REMAP_CH1_BIT];
  assign remapped[1] = TIMER2_REMAP_OPTIONS[REMAP_CH2_BIT];
  assign remapped[2] = TIMER2_REMAP_OPTIONS[REMAP_CH3_BIT];
  assign remapped[3] = TIMER2_REMAP_OPTIONS[REMAP_CH4_BIT];

  assign spi_mode = (SERIAL2_MODE_SELECT == SER_MODE_SPI);
  assign twi_mode = (SERIAL2_MODE_SELECT == SER_MODE_TWI);
  assign spi_master = SERIAL2_SPI_CONFIG[SPI_MASTER_BIT];

  // Each pad owns one four-bit field, pad n in the nth nibble
  genvar g;
  generate
    for (g = 0; g < PAD_COUNT; g++)
    begin : g_field
      assign field[g] = PORT_A_LOW_PAD_CONFIG[g*FIELD_WIDTH +: FIELD_WIDTH];
    end
  endgenerate

  // Per pad, does the timer own the alternate output (channel order 1,3,4,2)
  always_comb
  begin
    timer_drive[0] = !remapped[0] && TIMER2_CHANNEL_OUTPUT_ENABLES[0];
    timer_drive[1] = !remapped[2] && TIMER2_CHANNEL_OUTPUT_ENABLES[2];
    timer_drive[2] = !remapped[3] && TIMER2_CHANNEL_OUTPUT_ENABLES[3];
    timer_drive[3] = !remapped[1] && TIMER2_CHANNEL_OUTPUT_ENABLES[1];
    timer_free = ~timer_drive;
  end

  // Source selection; the timer wins over the serial controller on a shared pad
  // An alternate code with the wrong mode or role falls back to GPIO
  always_comb
  begin
    for (int p = 0; p < PAD_COUNT; p++)
    begin
      source[p] = SRC_GPIO;
    end
    if (field[0] == CFG_ANALOG && USB_FITTED)
    begin
      source[0] = SRC_ANALOG;
    end
    else if (field[0] == CFG_ALT_OUT && timer_drive[0])
    begin
      source[0] = SRC_TIMER;
    end
    else if (field[0] == CFG_ALT_OUT && timer_free[0] && spi_mode && spi_master)
    begin
      source[0] = SRC_SPI_OUT;
    end
    if (field[1] == CFG_ANALOG && USB_FITTED)
    begin
      source[1] = SRC_ANALOG;
    end
    else if (field[1] == CFG_ALT_OUT && timer_drive[1])
    begin
      source[1] = SRC_TIMER;
    end
    else if (field[1] == CFG_ALT_OD && timer_free[1] && twi_mode)
    begin
      source[1] = SRC_TWI_OD;
    end
    else if (field[1] == CFG_ALT_OUT && timer_free[1] && spi_mode && !spi_master)
    begin
      source[1] = SRC_SPI_OUT;
    end
    if (field[2] == CFG_ALT_OUT && timer_drive[2])
    begin
      source[2] = SRC_TIMER;
    end
    else if (field[2] == CFG_ALT_OD && timer_free[2] && twi_mode)
    begin
      source[2] = SRC_TWI_OD;
    end
    else if (field[2] == CFG_ALT_OUT && timer_free[2] && spi_mode && spi_master)
    begin
      source[2] = SRC_SPI_OUT;
    end
    if (field[3] == CFG_ALT_OUT && timer_drive[3])
    begin
      source[3] = SRC_TIMER;
    end
  end

  // Output levels and enables per pad
  always_comb
  begin
    for (int p = 0; p < PAD_COUNT; p++)
    begin
      pad_out_next[p] = 1'b0;
      pad_oe_next[p] = 1'b0;
      case (source[p])
        SRC_GPIO:
        begin
          // GPIO drives only when its field says output
          pad_out_next[p] = GPIO_OUT[p];
          pad_oe_next[p] = (field[p] == CFG_OUT);
        end
        SRC_TIMER:
        begin
          pad_oe_next[p] = 1'b1;
          case (p)
            0: pad_out_next[p] = TIMER2_CHANNEL_OUT[0];
            1: pad_out_next[p] = TIMER2_CHANNEL_OUT[2];
            2: pad_out_next[p] = TIMER2_CHANNEL_OUT[3];
            default: pad_out_next[p] = TIMER2_CHANNEL_OUT[1];
          endcase
        end
        SRC_SPI_OUT:
        begin
          pad_oe_next[p] = 1'b1;
          case (p)
            0: pad_out_next[p] = SERIAL2_SPI_MASTER_OUT;
            1: pad_out_next[p] = SERIAL2_SPI_SLAVE_OUT;
            default: pad_out_next[p] = SERIAL2_SPI_CLOCK_OUT;
          endcase
        end
        SRC_TWI_OD:
        begin
          // Open drain: only ever pulls low
          pad_out_next[p] = 1'b0;
          if (p == 1)
          begin
            pad_oe_next[p] = !SERIAL2_TWI_DATA_OUT;
          end
          else
          begin
            pad_oe_next[p] = !SERIAL2_TWI_CLOCK_OUT;
          end
        end
        SRC_ANALOG:
        begin
          // Digital driver released so the USB transceiver owns the pad
          pad_oe_next[p] = 1'b0;
        end
        default:
        begin
          pad_oe_next[p] = 1'b0;
        end
      endcase
    end
  end

  // Port B alternates carry channels 1..4 when remapped
  always_comb
  begin
    for (int c = 0; c < PAD_COUNT; c++)
    begin
      port_b_oe_next[c] = remapped[c] && TIMER2_CHANNEL_OUTPUT_ENABLES[c];
      port_b_out_next[c] = TIMER2_CHANNEL_OUT[c];
    end
  end

  // Capture inputs follow the remap choice
  // A remapped channel ignores its port A pad entirely
  always_comb
  begin
    timer_in_next[0] = remapped[0] ? port_b_in[0] : pad_in[0];
    timer_in_next[1] = remapped[1] ? port_b_in[1] : pad_in[3];
    timer_in_next[2] = remapped[2] ? port_b_in[2] : pad_in[1];
    timer_in_next[3] = remapped[3] ? port_b_in[3] : pad_in[2];
  end

  // Registered so pad enables never glitch while fields are rewritten
  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      PORT_A_PAD_OUT <= '0;
      PORT_A_PAD_OE <= '0;
      PORT_B_REMAP_OUT <= '0;
      PORT_B_REMAP_OE <= '0;
      USB_MINUS_LINE_EN <= 1'b0;
      USB_PLUS_LINE_EN <= 1'b0;
    end
    else
    begin
      PORT_A_PAD_OUT <= pad_out_next;
      PORT_A_PAD_OE <= pad_oe_next;
      PORT_B_REMAP_OUT <= port_b_out_next;
      PORT_B_REMAP_OE <= port_b_oe_next;
      USB_MINUS_LINE_EN <= (source[0] == SRC_ANALOG);
      USB_PLUS_LINE_EN <= (source[1] == SRC_ANALOG);
    end
  end

  // Capture and readback carry the same synchroniser delay
  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      TIMER2_CHANNEL_IN <= '0;
      GPIO_IN <= '0;
    end
    else
    begin
      TIMER2_CHANNEL_IN <= timer_in_next;
      GPIO_IN <= pad_in;
    end
  end

  // Serial inputs idle high when the mode or role does not select the pad
  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      SERIAL2_SPI_MASTER_IN <= 1'b1;
      SERIAL2_SPI_SLAVE_IN <= 1'b1;
      SERIAL2_SPI_CLOCK_IN <= 1'b1;
      SERIAL2_SPI_SLAVE_SELECT_N <= 1'b1;
      SERIAL2_TWI_DATA_IN <= 1'b1;
      SERIAL2_TWI_CLOCK_IN <= 1'b1;
    end
    else
    begin
      SERIAL2_SPI_SLAVE_IN <= (spi_mode && !spi_master) ? pad_in[0] : 1'b1;
      SERIAL2_SPI_MASTER_IN <= (spi_mode && spi_master) ? pad_in[1] : 1'b1;
      SERIAL2_SPI_CLOCK_IN <= (spi_mode && !spi_master) ? pad_in[2] : 1'b1;
      SERIAL2_SPI_SLAVE_SELECT_N <= (spi_mode && !spi_master) ? pad_in[3] : 1'b1;
      SERIAL2_TWI_DATA_IN <= twi_mode ? pad_in[1] : 1'b1;
      SERIAL2_TWI_CLOCK_IN <= twi_mode ? pad_in[2] : 1'b1;
    end
  end

  // Out-of-range selects read low rather than alias onto another pad
  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      FLEX_INTERRUPT_THREE <= 1'b0;
      FLEX_INTERRUPT_FOUR <= 1'b0;
    end
    else
    begin
      FLEX_INTERRUPT_THREE <= (int'(FLEX_INTERRUPT_THREE_PIN_SELECT) < DIGITAL_PADS) ?
        digital_in[FLEX_INTERRUPT_THREE_PIN_SELECT] : 1'b0;
      FLEX_INTERRUPT_FOUR <= (int'(FLEX_INTERRUPT_FOUR_PIN_SELECT) < DIGITAL_PADS) ?
        digital_in[FLEX_INTERRUPT_FOUR_PIN_SELECT] : 1'b0;
    end
  end
endmodule : port_a_low_pin_mux
`default_nettype wire

// file: verif/port_a_low_pin_mux_sva.sv
// Concurrent checks on the port A low pad multiplexer ports
`timescale 1ns/1ps
`default_nettype none
module port_a_low_pin_mux_sva
(
  input wire logic REF_CLK,
  input wire logic RESETN,
  input wire logic [15:0] PORT_A_LOW_PAD_CONFIG,
  input wire logic [3:0] GPIO_OUT,
  input wire logic [7:0] TIMER2_REMAP_OPTIONS,
  input wire logic [3:0] TIMER2_CHANNEL_OUTPUT_ENABLES,
  input wire logic [3:0] TIMER2_CHANNEL_OUT,
  input wire logic [7:0] SERIAL2_SPI_CONFIG,
  input wire pad_mux_pkg::serial_mode_t SERIAL2_MODE_SELECT,
  input wire logic SERIAL2_SPI_MASTER_OUT,
  input wire logic SERIAL2_TWI_DATA_OUT,
  input wire logic [3:0] PORT_A_PAD_IN,
  input wire logic [3:0] PORT_A_PAD_OUT,
  input wire logic [3:0] PORT_A_PAD_OE,
  input wire logic USB_MINUS_LINE_EN,
  input wire logic USB_PLUS_LINE_EN,
  input wire logic [3:0] PORT_B_REMAP_OUT,
  input wire logic [3:0] PORT_B_REMAP_OE,
  input wire logic [3:0] TIMER2_CHANNEL_IN
);
  import pad_mux_pkg::*;
  wire logic [15:0] cfg = PORT_A_LOW_PAD_CONFIG;
  wire logic [7:0] rm = TIMER2_REMAP_OPTIONS;
  wire logic [3:0] en = TIMER2_CHANNEL_OUTPUT_ENABLES;
  logic [1:0] live_reg;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RESETN);
  // Edges since reset release; $past must not reach back into reset
  always_ff @(posedge REF_CLK or negedge RESETN)
    if (!RESETN)
      live_reg <= 2'h0;
    else if (live_reg != 2'h3)
      live_reg <= live_reg + 2'h1;
  timer_pad0_a: assert property (
    live_reg != 2'h0 && $past(cfg[3:0] == CFG_ALT_OUT && !rm[4] && en[0])
    |-> PORT_A_PAD_OE[0] && PORT_A_PAD_OUT[0] == $past(TIMER2_CHANNEL_OUT[0]))
    else $error("timer 1 not on pad 0");
  spi_out_pad0_a: assert property (
    live_reg != 2'h0 && $past(cfg[3:0] == CFG_ALT_OUT && SERIAL2_MODE_SELECT == SER_MODE_SPI
    && SERIAL2_SPI_CONFIG[4] && !(en[0] && !rm[4]))
    |-> PORT_A_PAD_OE[0] && PORT_A_PAD_OUT[0] == $past(SERIAL2_SPI_MASTER_OUT))
    else $error("spi master out not on pad 0");
  usb_lines_a: assert property (
    live_reg != 2'h0 |-> USB_MINUS_LINE_EN == $past(cfg[3:0] == CFG_ANALOG)
    && USB_PLUS_LINE_EN == $past(cfg[7:4] == CFG_ANALOG))
    else $error("usb line enable wrong");
  twi_data_pad1_a: assert property (
    live_reg != 2'h0 && $past(SERIAL2_MODE_SELECT == SER_MODE_TWI && cfg[7:4] == CFG_ALT_OD
    && !(en[2] && !rm[6])) |-> !PORT_A_PAD_OUT[1]
    && PORT_A_PAD_OE[1] == !$past(SERIAL2_TWI_DATA_OUT))
    else $error("twi data not open drain on pad 1");
  timer_pad3_a: assert property (
    live_reg != 2'h0 && $past(cfg[15:12] == CFG_ALT_OUT && !rm[5] && en[1])
    |-> PORT_A_PAD_OE[3] && PORT_A_PAD_OUT[3] == $past(TIMER2_CHANNEL_OUT[1]))
    else $error("timer 2 not on pad 3");
  capture_in_a: assert property (
    live_reg == 2'h3 && $past(rm[5:4]) == 2'h0 && $past(rm[5:4], 3) == 2'h0
    |-> TIMER2_CHANNEL_IN[1:0] == {$past(PORT_A_PAD_IN[3], 3), $past(PORT_A_PAD_IN[0], 3)})
    else $error("capture input not from port a");
  remap_portb_a: assert property (
    live_reg != 2'h0 && $past(rm[6] && en[2])
    |-> PORT_B_REMAP_OE[2] && PORT_B_REMAP_OUT[2] == $past(TIMER2_CHANNEL_OUT[2]))
    else $error("remapped timer 3 not on port b");
  gpio_pad1_a: assert property (
    cfg[7:4] == CFG_OUT |=> PORT_A_PAD_OE[1] && PORT_A_PAD_OUT[1] == $past(GPIO_OUT[1]))
    else $error("gpio level not on pad 1");
  cover property (SERIAL2_MODE_SELECT == SER_MODE_TWI && PORT_A_PAD_OE[1]);
  cover property (USB_MINUS_LINE_EN && USB_PLUS_LINE_EN);
  cover property (PORT_B_REMAP_OE == 4'hf);
endmodule : port_a_low_pin_mux_sva
bind port_a_low_pin_mux port_a_low_pin_mux_sva i_sva (.REF_CLK(REF_CLK), .RESETN(RESETN),
  .PORT_A_LOW_PAD_CONFIG(PORT_A_LOW_PAD_CONFIG), .GPIO_OUT(GPIO_OUT),
  .TIMER2_REMAP_OPTIONS(TIMER2_REMAP_OPTIONS), .TIMER2_CHANNEL_OUT(TIMER2_CHANNEL_OUT),
  .TIMER2_CHANNEL_OUTPUT_ENABLES(TIMER2_CHANNEL_OUTPUT_ENABLES),
  .SERIAL2_SPI_CONFIG(SERIAL2_SPI_CONFIG), .SERIAL2_MODE_SELECT(SERIAL2_MODE_SELECT),
  .SERIAL2_SPI_MASTER_OUT(SERIAL2_SPI_MASTER_OUT), .SERIAL2_TWI_DATA_OUT(SERIAL2_TWI_DATA_OUT),
  .PORT_A_PAD_IN(PORT_A_PAD_IN), .PORT_A_PAD_OUT(PORT_A_PAD_OUT), .PORT_A_PAD_OE(PORT_A_PAD_OE),
  .USB_MINUS_LINE_EN(USB_MINUS_LINE_EN), .USB_PLUS_LINE_EN(USB_PLUS_LINE_EN),
  .PORT_B_REMAP_OUT(PORT_B_REMAP_OUT), .PORT_B_REMAP_OE(PORT_B_REMAP_OE),
  .TIMER2_CHANNEL_IN(TIMER2_CHANNEL_IN));
`default_nettype wire

// file: verif/periph_model.sv
// Far-side model of timer 2 and serial controller 2 output levels
`timescale 1ns/1ps
`default_nettype none
module periph_model
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hold,
  output logic [3:0] tco,
  output logic [4:0] ser
);
  logic [7:0] cnt_reg;
  // Odd stride so every level keeps moving while running
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      cnt_reg <= 8'h00;
    else if (!hold)
      cnt_reg <= cnt_reg + 8'h35;
  assign tco = cnt_reg[3:0];
  assign ser = cnt_reg[7:3];
endmodule : periph_model
`default_nettype wire

// file: verif/tb_port_a_low_pin_mux.sv
// Self-checking testbench for the port A low pad multiplexer
`timescale 1ns/1ps
`default_nettype none
module tb_port_a_low_pin_mux;
  import pad_mux_pkg::*;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic hold = 1'b1;
  logic [15:0] cfg = CFG_RESET;
  logic [3:0] gpio_o = 4'h0;
  logic [7:0] rm = 8'h00;
  logic [3:0] en = 4'h0;
  logic [7:0] spi = 8'h00;
  serial_mode_t md = SER_MODE_OFF;
  logic [3:0] pa = 4'h0;
  logic [3:0] pb = 4'h0;
  logic [31:0] dig = 32'h0;
  logic [4:0] s3 = 5'h0;
  logic [4:0] s4 = 5'h0;
  logic [3:0] tco, p_out, p_oe, pb_out, pb_oe, tci, g_in;
  logic [4:0] ser;
  logic um, up, mi, si, ci, ss, di, cli, f3, f4;
  int err_total = 0;
  int n_compared = 0;
  int cyc = 0;
  always #5 ref_clk = ~ref_clk;
  periph_model i_far (.clk(ref_clk), .rst_n(resetn), .hold(hold), .tco(tco), .ser(ser));
  port_a_low_pin_mux i_dut (.REF_CLK(ref_clk), .RESETN(resetn), .PORT_A_LOW_PAD_CONFIG(cfg),
    .GPIO_OUT(gpio_o), .TIMER2_REMAP_OPTIONS(rm), .TIMER2_CHANNEL_OUTPUT_ENABLES(en),
    .TIMER2_CHANNEL_OUT(tco), .SERIAL2_SPI_CONFIG(spi), .SERIAL2_MODE_SELECT(md),
    .SERIAL2_SPI_MASTER_OUT(ser[0]), .SERIAL2_SPI_SLAVE_OUT(ser[1]),
    .SERIAL2_SPI_CLOCK_OUT(ser[2]), .SERIAL2_TWI_DATA_OUT(ser[3]), .SERIAL2_TWI_CLOCK_OUT(ser[4]),
    .PORT_A_PAD_IN(pa), .PORT_B_REMAP_PAD_IN(pb), .DIGITAL_PAD_IN(dig),
    .FLEX_INTERRUPT_THREE_PIN_SELECT(s3), .FLEX_INTERRUPT_FOUR_PIN_SELECT(s4),
    .PORT_A_PAD_OUT(p_out), .PORT_A_PAD_OE(p_oe), .USB_MINUS_LINE_EN(um), .USB_PLUS_LINE_EN(up),
    .PORT_B_REMAP_OUT(pb_out), .PORT_B_REMAP_OE(pb_oe), .TIMER2_CHANNEL_IN(tci),
    .SERIAL2_SPI_MASTER_IN(mi), .SERIAL2_SPI_SLAVE_IN(si), .SERIAL2_SPI_CLOCK_IN(ci),
    .SERIAL2_SPI_SLAVE_SELECT_N(ss), .SERIAL2_TWI_DATA_IN(di), .SERIAL2_TWI_CLOCK_IN(cli),
    .GPIO_IN(g_in), .FLEX_INTERRUPT_THREE(f3), .FLEX_INTERRUPT_FOUR(f4));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Four edges cover the longest path, pad sync plus output stage
  task automatic settle();
    repeat (4) @(posedge ref_clk);
    #1;
  endtask : settle
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : results
  task automatic t_reset();
    @(posedge ref_clk);
    resetn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    chk({ss, mi, si, ci, di, cli, p_oe, um}, {6'h3f, 5'h0});
    @(posedge ref_clk);
    resetn <= 1'b1;
  endtask : t_reset
  task automatic t_timer();
    @(posedge ref_clk);
    cfg <= 16'h9999;
    en <= 4'hf;
    hold <= 1'b0;
    repeat (6) @(posedge ref_clk);
    hold <= 1'b1;
    settle();
    chk({p_oe, p_out}, {4'hf, tco[1], tco[3], tco[2], tco[0]});
    @(posedge ref_clk);
    rm <= 8'hf0;
    settle();
    chk({pb_oe, p_oe, pb_out}, {8'hf0, tco});
  endtask : t_timer
  task automatic t_spi();
    @(posedge ref_clk);
    rm <= 8'h00;
    en <= 4'h0;
    md <= SER_MODE_SPI;
    spi <= 8'h10;
    settle();
    chk({p_oe, p_out[2], p_out[0], mi, si, ci, ss}, {4'h5, ser[2], ser[0], 4'h7});
    @(posedge ref_clk);
    en <= 4'h1;
    settle();
    chk({p_oe[0], p_out[0]}, {1'b1, tco[0]});
    @(posedge ref_clk);
    en <= 4'h0;
    spi <= 8'h00;
    pa <= 4'h4;
    settle();
    chk({p_oe, p_out[1], mi, si, ci, ss}, {4'h2, ser[1], 4'ha});
  endtask : t_spi
  task automatic t_twi();
    @(posedge ref_clk);
    cfg <= 16'h4dd4;
    md <= SER_MODE_TWI;
    for (int i = 0; i < 2; i++)
    begin
      @(posedge ref_clk);
      hold <= 1'b0;
      @(posedge ref_clk);
      hold <= 1'b1;
      settle();
      chk({p_oe[2:1], p_out[2:1], di, cli}, {~ser[4], ~ser[3], 4'h1});
    end
  endtask : t_twi
  task automatic t_pads();
    @(posedge ref_clk);
    md <= SER_MODE_OFF;
    cfg <= 16'h4400;
    settle();
    chk({um, up, p_oe}, 6'h30);
    @(posedge ref_clk);
    cfg <= 16'h1111;
    gpio_o <= 4'ha;
    pa <= 4'h9;
    settle();
    chk({p_oe, p_out, g_in}, 12'hfa9);
    @(posedge ref_clk);
    cfg <= 16'h4444;
    settle();
    chk({p_oe, tci}, 8'h03);
    @(posedge ref_clk);
    rm <= 8'hf0;
    pb <= 4'h6;
    settle();
    chk(tci, 4'h6);
  endtask : t_pads
  task automatic t_flex();
    logic [4:0] k;
    for (int i = 0; i < 3; i++)
    begin
      k = 5'(i * 31 / 2);
      @(posedge ref_clk);
      dig <= 32'h1 << k;
      s3 <= k;
      s4 <= k ^ 5'h1;
      settle();
      chk({f3, f4}, 2'b10);
    end
  endtask : t_flex
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      err_total++;
      results();
    end
  end
  initial
  begin
    repeat (16) @(posedge ref_clk);
    t_reset();
    t_timer();
    t_spi();
    t_twi();
    t_pads();
    t_reset();
    t_flex();
    results();
  end
endmodule : tb_port_a_low_pin_mux
`default_nettype wire
